// file: verilog/door_regs.svh
`ifndef DOOR_REGS_SVH
`define DOOR_REGS_SVH

// Frame geometry
`define FRAME_BITS 24
`define FRAME_LEN 5'h18
`define CNT_MAX 5'h1F

// Input register 0 fields
`define BIT_SEL 0
`define BIT_CM_LO 18
`define BIT_CM_HI 19
`define BIT_RDIS 20
`define BIT_CLR 22
`define BIT_ENABLE 23

// Driver fields, shared by both input registers
`define DRV_LO 1
`define DRV_HI 17
`define NUM_DRV 17
`define NUM_BRIDGE 6
`define NUM_TESTBR 3

// Status register fields
`define ST_FAULT 0
`define ST_TW 19
`define ST_TSD 20
`define ST_UV 21
`define ST_OV 22
`define ST_ALWAYS 23
`define ST1_USED 17

// Test mode output selection codes, bridge 3..1 both-on
`define TSEL_FAULT 3'h0
`define TSEL_SDI 3'h1
`define TSEL_SCLK 3'h2
`define TSEL_OSC 3'h3
`define TSEL_PWMA 3'h4
`define TSEL_PWMB 3'h5

// Synchroniser widths
`define SER_W 7
`define ANA_W 38
`define SER_RST 7'h40

`endif

// file: verilog/door_pkg.sv
package door_pkg;
`include "door_regs.svh"

  typedef logic [`FRAME_BITS-1:0] frame_word_t;
  typedef logic [`ST_OV:1] status_flags_t;

  typedef struct packed {
    logic sclk_p;
    logic csn_p;
    logic [4:0] cnt;
    logic loaded;
    frame_word_t rx;
    frame_word_t tx;
    logic so;
    frame_word_t ctrl0;
    frame_word_t ctrl1;
    status_flags_t st0;
    status_flags_t st1;
    logic active;
    logic [`NUM_DRV-1:0] drv;
  } spi_state_t;

endpackage

// file: verilog/bit_sync.sv
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_q <= RST;
      q_o <= RST;
    end
    else
    begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule

// file: verilog/half_bridge_gate.sv
`timescale 1ns/1ps
module half_bridge_gate (
  input wire logic lo_cmd_i,
  input wire logic hi_cmd_i,
  output logic lo_on_o,
  output logic hi_on_o,
  output logic both_cmd_o
);
  // Both commanded means neither side conducts
  assign both_cmd_o = lo_cmd_i & hi_cmd_i;
  assign lo_on_o = lo_cmd_i & ~hi_cmd_i;
  assign hi_on_o = hi_cmd_i & ~lo_cmd_i;
endmodule

// file: verilog/door_driver_spi_frame_logic.sv
// Summary of operation
// RQ1 - Sample serial_in on clock rise, shift 24 bits
// RQ2 - Commit only exactly 24 clocks at select rise
// RQ3 - Select low drives fault bit on output
// RQ4 - First clock rise loads selected status word
// RQ5 - Later clock falls shift next status bit
// RQ6 - Bit 0 picks input and status register
// RQ7 - Bits 1-17 switch matching output drivers
// RQ8 - Bit 23 active; zero gives standby, clear
// RQ9 - Reset starts standby with outputs off
// RQ10 - Bits 18-19 steer current monitor mux
// RQ11 - Bit 22 clears both status registers
// RQ12 - Fault bit combines status bits 1-22
// RQ13 - Over-current disables driver until cleared
// RQ14 - Thermal shutdown forces all drivers off
// RQ15 - Never both sides of half-bridge on
// RQ16 - Test mode muxes chosen signal to output
// RQ17 - Status 0 bit 23 reads one
// RQ18 - Over/undervoltage sets status, outputs off
// RQ19 - Frames travel least significant bit first
// RQ20 - Output high impedance while select high; code drives it while test mode is on
// RQ21 - Test mode follows dedicated test input
`timescale 1ns/1ps
`include "door_regs.svh"
module door_driver_spi_frame_logic
  import door_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic frame_select_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_in_i,
  input wire logic test_mode_i,
  input wire logic pulse_gate_a_i,
  input wire logic pulse_gate_b_i,
  input wire logic osc_2mhz_i,
  input wire logic [`NUM_DRV-1:0] overcurrent_i,
  input wire logic [`NUM_DRV-1:0] open_load_i,
  input wire logic thermal_shutdown_flag_i,
  input wire logic temp_warning_flag_i,
  input wire logic overvoltage_i,
  input wire logic undervoltage_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  output logic [`NUM_DRV-1:0] driver_on_o,
  output logic [1:0] current_monitor_sel_o,
  output logic active_o
);
  spi_state_t s_q;
  spi_state_t s_d;
  logic [`SER_W-1:0] ser_s;
  logic [`ANA_W-1:0] ana_s;
  logic csn_s;
  logic sclk_s;
  logic sdi_s;
  logic test_s;
  logic pwma_s;
  logic pwmb_s;
  logic osc_s;
  logic [`NUM_DRV-1:0] oc_s;
  logic [`NUM_DRV-1:0] ol_s;
  logic tsd_s;
  logic tw_s;
  logic ov_s;
  logic uv_s;
  logic csn_fell;
  logic csn_rose;
  logic sclk_rise;
  logic sclk_fall;
  logic commit;
  logic standby_cmd;
  logic status_clr;
  logic fault_w;
  frame_word_t status0_w;
  frame_word_t status1_w;
  status_flags_t ev0;
  status_flags_t ev1;
  logic [`NUM_DRV-1:0] cmd_w;
  logic [`NUM_DRV-1:0] gated_w;
  logic [`NUM_DRV-1:0] oc_block;
  logic [`NUM_BRIDGE-1:0] both_w;
  logic [`NUM_BRIDGE-1:0] shoot_w;
  logic [2:0] tsel;
  logic outputs_ok;
  logic tmux;

  // Every pin from outside except clock and reset passes two flops before use
  bit_sync #(.W(`SER_W), .RST(`SER_RST)) u_ser_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .d_i({frame_select_n_i, serial_clk_i, serial_in_i, test_mode_i,
          pulse_gate_a_i, pulse_gate_b_i, osc_2mhz_i}),
    .q_o(ser_s)
  );

  bit_sync #(.W(`ANA_W)) u_ana_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .d_i({overcurrent_i, open_load_i, thermal_shutdown_flag_i,
          temp_warning_flag_i, overvoltage_i, undervoltage_i}),
    .q_o(ana_s)
  );

  // Select synchroniser resets high, so reset makes no false edge
  assign {csn_s, sclk_s, sdi_s, test_s, pwma_s, pwmb_s, osc_s} = ser_s;
  assign {oc_s, ol_s, tsd_s, tw_s, ov_s, uv_s} = ana_s;

  assign csn_fell = ~csn_s & s_q.csn_p;
  assign csn_rose = csn_s & ~s_q.csn_p;
  assign sclk_rise = sclk_s & ~s_q.sclk_p;
  assign sclk_fall = ~sclk_s & s_q.sclk_p;

  assign commit = csn_rose & (s_q.cnt == `FRAME_LEN); // [RQ2]
  assign standby_cmd = commit & ~s_q.rx[`BIT_ENABLE]; // [RQ8]
  assign status_clr = (commit & s_q.rx[`BIT_CLR]) | standby_cmd; // [RQ11]

  // Status events from the analog side
  always_comb
  begin
    ev0 = '0;
    ev1 = '0;
    ev0[`DRV_HI:`DRV_LO] = oc_s;
    ev0[`ST_TW] = tw_s;
    ev0[`ST_TSD] = tsd_s;
    ev0[`ST_UV] = uv_s; // [RQ18]
    ev0[`ST_OV] = ov_s; // [RQ18]
    ev1[`DRV_HI:`DRV_LO] = ol_s;
  end

  assign fault_w = (|s_q.st0) | (|s_q.st1); // [RQ12]
  assign status0_w = {1'b1, s_q.st0, fault_w}; // [RQ17]
  assign status1_w = {1'b0, s_q.st1, fault_w};

  // Driver command and half-bridge interlock
  assign cmd_w = s_q.ctrl0[`DRV_HI:`DRV_LO]; // [RQ7]

  genvar g;
  generate
    for (g = 0; g < `NUM_BRIDGE; g++)
    begin : g_bridge
      half_bridge_gate u_gate (
        .lo_cmd_i(cmd_w[2*g]),
        .hi_cmd_i(cmd_w[2*g+1]),
        .lo_on_o(gated_w[2*g]),
        .hi_on_o(gated_w[2*g+1]),
        .both_cmd_o(both_w[g])
      ); // [RQ15]
      assign shoot_w[g] = driver_on_o[2*g] & driver_on_o[2*g+1];
    end
  endgenerate
  assign gated_w[`NUM_DRV-1:2*`NUM_BRIDGE] =
    cmd_w[`NUM_DRV-1:2*`NUM_BRIDGE];

  // Latched over-current holds off unless recovery is set
  assign oc_block = oc_s |
    (s_q.st0[`DRV_HI:`DRV_LO] & ~s_q.ctrl1[`DRV_HI:`DRV_LO]); // [RQ13]

  assign outputs_ok = s_q.active // [RQ9]
    & ~s_q.st0[`ST_TSD] // [RQ14]
    & ~ov_s & ~uv_s // [RQ18]
    & ~(s_q.ctrl0[`BIT_RDIS] & (s_q.st0[`ST_UV] | s_q.st0[`ST_OV]));

  // Test output selection by both-on bridges 1 to 3
  assign tsel = both_w[`NUM_TESTBR-1:0];
  always_comb
  begin
    unique case (tsel)
      `TSEL_SDI: tmux = sdi_s; // [RQ16]
      `TSEL_SCLK: tmux = sclk_s;
      `TSEL_OSC: tmux = osc_s;
      `TSEL_PWMA: tmux = pwma_s;
      `TSEL_PWMB: tmux = pwmb_s;
      default: tmux = fault_w;
    endcase
  end

  always_comb
  begin
    s_d = s_q;
    s_d.sclk_p = sclk_s;
    s_d.csn_p = csn_s;
    // Events win over a clear in the same cycle
    s_d.st0 = (status_clr ? '0 : s_q.st0) | ev0; // [RQ11]
    s_d.st1 = (status_clr ? '0 : s_q.st1) | ev1;
    if (csn_fell)
    begin
      s_d.cnt = '0;
      s_d.loaded = 1'b0;
    end
    else if (!csn_s && sclk_rise)
    begin
      s_d.rx = {sdi_s, s_q.rx[`FRAME_BITS-1:1]}; // [RQ1] [RQ19]
      if (s_q.cnt != `CNT_MAX)
      begin
        s_d.cnt = s_q.cnt + 5'h01;
      end
      if (!s_q.loaded)
      begin
        s_d.loaded = 1'b1;
        s_d.tx = sdi_s ? status1_w : status0_w; // [RQ4] [RQ6]
      end
    end
    else if (!csn_s && sclk_fall && s_q.loaded)
    begin
      s_d.so = s_q.tx[1]; // [RQ5] [RQ19]
      s_d.tx = {1'b0, s_q.tx[`FRAME_BITS-1:1]};
    end
    if (!s_q.loaded || csn_s)
    begin
      s_d.so = fault_w; // [RQ3]
    end
    if (test_s)
    begin
      s_d.so = tmux; // [RQ16] [RQ21]
    end
    if (standby_cmd)
    begin
      s_d.active = 1'b0; // [RQ8]
      s_d.ctrl0 = '0;
      s_d.ctrl1 = '0;
    end
    else if (commit)
    begin
      s_d.active = 1'b1;
      if (s_q.rx[`BIT_SEL])
      begin
        s_d.ctrl1 = s_q.rx; // [RQ6]
      end
      else
      begin
        s_d.ctrl0 = s_q.rx; // [RQ6]
      end
    end
    s_d.drv = outputs_ok ? (gated_w & ~oc_block) : '0; // [RQ13] [RQ14]
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_q <= '0; // [RQ9]
      s_q.csn_p <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign serial_out_o = s_q.so;
  assign serial_out_oe_o = ~csn_s | test_s; // [RQ3] [RQ20] [RQ21]
  assign driver_on_o = s_q.drv;
  assign current_monitor_sel_o = s_q.ctrl0[`BIT_CM_HI:`BIT_CM_LO]; // [RQ10]
  assign active_o = s_q.active;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);

  a_oe_while_sel: assert property (!csn_s |-> serial_out_oe_o) // [RQ3]
    else $error("output driver off while selected");

  a_hiz_when_idle: assert property ( // [RQ20]
    csn_s && !test_s |-> !serial_out_oe_o)
    else $error("output driven while deselected");

  a_fault_on_line: assert property ( // [RQ3]
    !csn_s && !s_q.loaded && !test_s |=> serial_out_o == $past(fault_w))
    else $error("fault bit not on output");

  a_rx_shift_lsb: assert property ( // [RQ1]
    !csn_s && !csn_fell && sclk_rise
      |=> s_q.rx[`FRAME_BITS-1] == $past(sdi_s))
    else $error("serial bit not shifted in");

  a_bad_len_drop: assert property ( // [RQ2]
    csn_rose && s_q.cnt != `FRAME_LEN |=> $stable(s_q.ctrl0)
      && $stable(s_q.ctrl1) && $stable(s_q.active))
    else $error("short or long frame committed");

  a_commit_reg0: assert property ( // [RQ6]
    commit && s_q.rx[`BIT_ENABLE] && !s_q.rx[`BIT_SEL]
      |=> s_q.ctrl0 == $past(s_q.rx))
    else $error("frame not written to register 0");

  a_standby_clr: assert property ( // [RQ8]
    standby_cmd |=> !active_o && s_q.ctrl0 == '0 ##1 driver_on_o == '0)
    else $error("standby did not clear");

  a_status_clr: assert property ( // [RQ11]
    commit && s_q.rx[`BIT_CLR] && ev0 == '0 && ev1 == '0 |=> !fault_w)
    else $error("status not cleared");

  a_no_shoot: assert property (shoot_w == '0) // [RQ15]
    else $error("half-bridge both sides on");

  a_tsd_off: assert property ( // [RQ14]
    s_q.st0[`ST_TSD] |=> driver_on_o == '0)
    else $error("drivers on in thermal shutdown");

  a_top_bit: assert property ( // [RQ17]
    !csn_s && !csn_fell && sclk_rise && !s_q.loaded && !sdi_s
      |=> s_q.tx[`ST_ALWAYS])
    else $error("status 0 top bit low");

  a_tx_load_sel: assert property ( // [RQ4]
    !csn_s && !csn_fell && sclk_rise && !s_q.loaded |=> s_q.tx ==
      ($past(sdi_s) ? $past(status1_w) : $past(status0_w)))
    else $error("wrong status word loaded");

  a_tx_shift_out: assert property ( // [RQ5]
    !csn_s && !csn_fell && sclk_fall && s_q.loaded && !test_s
      |=> serial_out_o == $past(s_q.tx[1]))
    else $error("status bit not shifted out");

  a_drv_follow: assert property ( // [RQ7]
    outputs_ok && oc_block == '0 && both_w == '0
      |=> driver_on_o == $past(cmd_w))
    else $error("driver does not follow control");

  a_cm_sel: assert property ( // [RQ10]
    commit && s_q.rx[`BIT_ENABLE] && !s_q.rx[`BIT_SEL]
      |=> current_monitor_sel_o == $past(s_q.rx[`BIT_CM_HI:`BIT_CM_LO]))
    else $error("monitor select not written");

  a_oc_off: assert property ( // [RQ13]
    oc_block != '0 |=> (driver_on_o & $past(oc_block)) == '0)
    else $error("driver on during over-current");

  a_ov_off: assert property ( // [RQ18]
    ov_s |=> s_q.st0[`ST_OV] && driver_on_o == '0)
    else $error("overvoltage not flagged or drivers on");

  a_uv_off: assert property ( // [RQ18]
    uv_s |=> s_q.st0[`ST_UV] && driver_on_o == '0)
    else $error("undervoltage not flagged or drivers on");

  a_test_sdi: assert property ( // [RQ16]
    test_s && tsel == `TSEL_SDI |=> serial_out_o == $past(sdi_s))
    else $error("test output not serial input");

  a_test_osc: assert property ( // [RQ16]
    test_s && tsel == `TSEL_OSC |=> serial_out_o == $past(osc_s))
    else $error("test output not oscillator");

  a_standby_off: assert property ( // [RQ9]
    !s_q.active |=> driver_on_o == '0)
    else $error("drivers on in standby");

  c_good_frame: cover property (commit && s_q.rx[`BIT_ENABLE]);
  c_bad_frame: cover property (csn_rose && s_q.cnt != `FRAME_LEN);
  c_test_mux: cover property (test_s && tsel == `TSEL_SCLK);
  c_standby: cover property (standby_cmd);
  c_status_clr: cover property (status_clr && s_q.rx[`BIT_CLR]);
endmodule

// file: tb/host_spi_master.sv
`timescale 1ns/1ps
module host_spi_master (
  input wire logic clk_sys_i,
  input wire logic serial_out_i,
  input wire logic serial_out_oe_i,
  output logic frame_select_n_o,
  output logic serial_clk_o,
  output logic serial_in_o
);
  initial
  begin
    frame_select_n_o = 1'b1;
    serial_clk_o = 1'b0;
    serial_in_o = 1'b0;
  end
  // Mode 0 frame, clock runs only while selected
  task automatic xfer(input logic [23:0] w, input int n,
                      output logic [23:0] r);
    r = 24'h0;
    @(posedge clk_sys_i) #1;
    frame_select_n_o = 1'b0;
    #64;
    for (int i = 0; i < n; i++)
    begin
      serial_in_o = (i < 24) ? w[i] : 1'b0;
      #32;
      // An undriven line reads inverted
      if (i < 24)
        r[i] = serial_out_oe_i ? serial_out_i : ~serial_out_i;
      serial_clk_o = 1'b1;
      #32;
      serial_clk_o = 1'b0;
    end
    #32;
    frame_select_n_o = 1'b1;
    #64;
  endtask
  // Select low without clocks: fault poll
  task automatic poll(output logic [1:0] p);
    @(posedge clk_sys_i) #1;
    frame_select_n_o = 1'b0;
    #64;
    p = {serial_out_oe_i, serial_out_oe_i ? serial_out_i : ~serial_out_i};
    frame_select_n_o = 1'b1;
    #64;
  endtask
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  localparam logic [23:0] W0 = 24'h880002;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic test_mode_i = 1'b0;
  logic [16:0] oc = 17'h0;
  logic [16:0] ol = 17'h0;
  logic thermal_shutdown_flag = 1'b0;
  logic ov = 1'b0;
  logic uv = 1'b0;
  logic pga = 1'b0;
  logic pgb = 1'b1;
  logic osc = 1'b1;
  logic frame_select_n, sclk, sdi, so, oe, act;
  logic [16:0] drv;
  logic [1:0] cm;
  logic [23:0] r;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  door_driver_spi_frame_logic i_door_driver_spi_frame_logic (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .frame_select_n_i(frame_select_n),
    .serial_clk_i(sclk),
    .serial_in_i(sdi),
    .test_mode_i(test_mode_i),
    .pulse_gate_a_i(pga),
    .pulse_gate_b_i(pgb),
    .osc_2mhz_i(osc),
    .overcurrent_i(oc),
    .open_load_i(ol),
    .thermal_shutdown_flag_i(thermal_shutdown_flag),
    .temp_warning_flag_i(1'b0),
    .overvoltage_i(ov),
    .undervoltage_i(uv),
    .serial_out_o(so),
    .serial_out_oe_o(oe),
    .driver_on_o(drv),
    .current_monitor_sel_o(cm),
    .active_o(act)
  );

  host_spi_master i_host_spi_master (
    .clk_sys_i(clk_sys_i),
    .serial_out_i(so),
    .serial_out_oe_i(oe),
    .frame_select_n_o(frame_select_n),
    .serial_clk_o(sclk),
    .serial_in_o(sdi)
  );

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wr(input logic [23:0] w, input int n = 24);
    i_host_spi_master.xfer(w, n, r);
    wt(4);
  endtask

  task automatic chk(input logic [23:0] got, exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("Compares %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      $display("MISMATCH t=%0t timeout", $time);
      wrap_up();
    end
  end

  initial
  begin
    logic [1:0] p;
    int sb[4] = '{1, 20, 22, 21};
    logic [23:0] tw[6] = '{24'h0, 24'h6, 24'h18, 24'h1E, 24'h60, 24'h66};
    logic [5:0] tx = 6'h2A;
    wt(4);
    arst_n_i = 1'b1;
    wt(4);
    chk(24'(act), 24'h0, "standby");
    chk(24'(drv), 24'h0, "drivers");
    chk(24'(oe), 24'h0, "idle hiz");
    $display("test reset done");
    wr(W0);
    chk(24'(act), 24'h1, "active");
    chk(24'(drv), 24'h1, "drivers");
    chk(24'(cm), 24'h2, "monitor");
    wr(24'h800008, 23);
    chk(24'(drv), 24'h1, "short frame");
    wr(24'h800008, 25);
    chk(24'(drv), 24'h1, "long frame");
    wr(24'h80001A);
    chk(24'(drv), 24'h1, "both sides");
    wr(W0);
    chk(r, 24'h800000, "status0");
    $display("test write done");
    for (int k = 0; k < 4; k++)
    begin
      {uv, ov, thermal_shutdown_flag, oc[0]} = 4'(1 << k);
      wt(8);
      chk(24'(drv), 24'h0, "event off");
      i_host_spi_master.poll(p);
      chk(24'(p), 24'h3, "poll");
      wr(W0);
      chk(r, 24'h800001 | (24'h1 << sb[k]), "flag");
      {uv, ov, thermal_shutdown_flag, oc[0]} = 4'h0;
      wt(8);
      chk(24'(drv), k < 2 ? 24'h0 : 24'h1, "hold");
      wr(W0 | 24'h400000);
      wr(W0);
      chk(r, 24'h800000, "cleared");
      chk(24'(drv), 24'h1, "back on");
    end
    $display("test events done");
    ol[16] = 1'b1;
    wt(8);
    wr(24'h800001);
    chk(r, 24'h020001, "status1");
    chk(24'(drv), 24'h1, "reg0 kept");
    ol[16] = 1'b0;
    wt(8);
    wr(W0 | 24'h400000);
    $display("test status1 done");
    arst_n_i = 1'b0;
    wt(4);
    arst_n_i = 1'b1;
    wt(4);
    chk(24'(act), 24'h0, "reset standby");
    chk(24'(drv), 24'h0, "reset drivers");
    chk(24'(cm), 24'h0, "reset monitor");
    chk(24'(oe), 24'h0, "reset hiz");
    $display("test mid reset done");
    test_mode_i = 1'b1;
    for (int c = 0; c < 6; c++)
    begin
      wr(24'h800000 | tw[c]);
      chk(24'(so), 24'(tx[c]), "test mux");
      chk(24'(oe), 24'h1, "test oe");
      {pga, pgb, osc} = ~{pga, pgb, osc};
      wt(4);
      chk(24'(so), 24'(tx[c] ^ (c > 2)), "test mux inv");
      {pga, pgb, osc} = ~{pga, pgb, osc};
    end
    test_mode_i = 1'b0;
    wt(4);
    chk(24'(oe), 24'h0, "test exit");
    $display("test mode done");
    wr(24'h000002);
    chk(24'(act), 24'h0, "standby");
    chk(24'(drv), 24'h0, "standby drv");
    chk(24'(cm), 24'h0, "standby cm");
    $display("test standby done");
    wrap_up();
  end
endmodule
